// File: pkg/iodr_pkg.sv
//////////////////////////////////////////////////////////////////////////////
//////////////////////////////////////////////////////////////////////////////
package iodr_pkg;

    localparam int unsigned DATA_W     = 16;
    localparam int unsigned ADDR_W     = 7;
    localparam int unsigned NUM_REGS   = 11;
    localparam int unsigned IDX_W      = 4;

    // Byte addresses of the low byte of each word
    localparam logic [6:0] ADDR_GYRO_X   = 7'h04;
    localparam logic [6:0] ADDR_GYRO_Y   = 7'h06;
    localparam logic [6:0] ADDR_GYRO_Z   = 7'h08;
    localparam logic [6:0] ADDR_ACCEL_X  = 7'h0A;
    localparam logic [6:0] ADDR_ACCEL_Y  = 7'h0C;
    localparam logic [6:0] ADDR_ACCEL_Z  = 7'h0E;
    localparam logic [6:0] ADDR_MAG_X    = 7'h10;
    localparam logic [6:0] ADDR_MAG_Y    = 7'h12;
    localparam logic [6:0] ADDR_MAG_Z    = 7'h14;
    localparam logic [6:0] ADDR_PRESSURE = 7'h16;
    localparam logic [6:0] ADDR_TEMP     = 7'h18;

    // Bank indices derived from the addresses
    localparam logic [3:0] IDX_MAG_X    = 4'h6;
    localparam logic [3:0] IDX_PRESSURE = 4'h9;

    localparam logic [15:0] DATA_RESET  = 16'h0000;

    // Serial frame layout
    localparam int unsigned FRAME_BITS = 16;
    localparam int unsigned RW_BIT     = 15;
    localparam int unsigned ADDR_MSB   = 14;
    localparam int unsigned ADDR_LSB   = 8;
    localparam logic [3:0]  LAST_BIT   = 4'hF;

    // Decimation field and mag low bits
    localparam int unsigned DEC_MSB       = 12;
    localparam int unsigned DEC_LSB       = 8;
    localparam logic [4:0]  MAG_LOW_BITS  = 5'h04;
    localparam int unsigned TEMP_BITS     = 12;

    // Timing
    localparam longint CLK_HZ          = 200000000;
    localparam longint SAMPLE_MILLISPS = 819200;
    localparam longint SAMPLE_CYC      = (CLK_HZ * 1000) / SAMPLE_MILLISPS;
    localparam int unsigned MAG_DIV    = 16;
    localparam int unsigned CLK_PER_NS = 5;
    localparam int unsigned PULSE_NS   = 1000;
    localparam int unsigned PULSE_CYC  = (PULSE_NS + CLK_PER_NS - 1) / CLK_PER_NS;

endpackage

// File: hw/iodr_spi_slave.sv
`timescale 1ns/10ps
`default_nettype none
module iodr_spi_slave
    import iodr_pkg::*;
(
    input  wire logic                spi_clk_i,
    input  wire logic                rstn_i,
    input  wire logic                cs_n_i,
    input  wire logic                mosi_i,
    input  wire logic [DATA_W-1:0]   tx_word_i,
    output logic                     miso_o,
    output logic                     miso_oe_o,
    output logic                     req_valid_o,
    output logic                     req_rw_o,
    output logic [ADDR_W-1:0]        req_addr_o
);

    // Frame logic is cleared whenever select is high, so a stopped clock is harmless
    wire frame_rst_n = rstn_i & ~cs_n_i;

    logic [3:0]        bit_cnt_reg;
    logic [14:0]       rx_reg;
    logic [15:0]       tx_reg;
    logic              frame_end;

    assign frame_end = (bit_cnt_reg == LAST_BIT);

    //////////////////////////////////////////////////////////////////////////
    always_ff @(posedge spi_clk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            bit_cnt_reg <= 4'h0;
            rx_reg      <= 15'h0000;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            rx_reg      <= {rx_reg[13:0], mosi_i};
        end
    end

    // Request survives select going high; short frames never reach it
    always_ff @(posedge spi_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            req_valid_o <= 1'b0;
            req_rw_o    <= 1'b0;
            req_addr_o  <= 7'h00;
        end else if (frame_end) begin
            req_valid_o <= 1'b1;
            req_rw_o    <= rx_reg[14];
            req_addr_o  <= rx_reg[13:7];
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Mode 3: shift out on falling edges, first edge loads the whole word
    always_ff @(negedge spi_clk_i or negedge frame_rst_n) begin
        if (!frame_rst_n) begin
            tx_reg    <= 16'h0000;
            miso_o    <= 1'b0;
            miso_oe_o <= 1'b0;
        end else begin
            miso_oe_o <= 1'b1;
            if (bit_cnt_reg == 4'h0) begin
                miso_o <= tx_word_i[15];
                tx_reg <= {tx_word_i[14:0], 1'b0};
            end else begin
                miso_o <= tx_reg[15];
                tx_reg <= {tx_reg[14:0], 1'b0};
            end
        end
    end

endmodule // iodr_spi_slave
`default_nettype wire

// File: hw/iodr_top.sv
`timescale 1ns/10ps
`default_nettype none
module iodr_top
    import iodr_pkg::*;
#(
    parameter int unsigned SAMPLE_CYCLES = int'(SAMPLE_CYC),
    parameter int unsigned PULSE_CYCLES  = PULSE_CYC,
    parameter int unsigned MAG_DIVIDE    = MAG_DIV
)(
    input  wire logic                sys_clk_i,
    input  wire logic                rstn_i,
    input  wire logic                spi_clk_i,
    input  wire logic                spi_cs_n_i,
    input  wire logic                spi_mosi_i,
    output logic                     spi_miso_o,
    output logic                     spi_miso_oe_o,
    input  wire logic [15:0]         gyro_x_i,
    input  wire logic [15:0]         gyro_y_i,
    input  wire logic [15:0]         gyro_z_i,
    input  wire logic [15:0]         accel_x_i,
    input  wire logic [15:0]         accel_y_i,
    input  wire logic [15:0]         accel_z_i,
    input  wire logic [15:0]         mag_x_i,
    input  wire logic [15:0]         mag_y_i,
    input  wire logic [15:0]         mag_z_i,
    input  wire logic [15:0]         pressure_i,
    input  wire logic [11:0]         temperature_i,
    input  wire logic [15:0]         sample_period_decimation_field_i,
    output logic                     first_digital_io_line_o
);

    //////////////////////////////////////////////////////////////////////////
    // Address decode: odd byte address hits the same word as its even partner
    function automatic logic [4:0] reg_lookup(input logic [6:0] addr);
        logic [5:0] word;
        logic [5:0] rel;
        word = addr[6:1];
        rel  = word - ADDR_GYRO_X[6:1];
        if ((addr >= ADDR_GYRO_X) && (addr <= (ADDR_TEMP + 7'h01))) begin
            reg_lookup = {1'b1, rel[3:0]};
        end else begin
            reg_lookup = 5'h00;
        end
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // Link side
    logic              req_valid;
    logic              req_rw;
    logic [6:0]        req_addr;
    logic [15:0]       read_word_reg;

    iodr_spi_slave u_spi (
        .spi_clk_i   (spi_clk_i),
        .rstn_i      (rstn_i),
        .cs_n_i      (spi_cs_n_i),
        .mosi_i      (spi_mosi_i),
        .tx_word_i   (read_word_reg),
        .miso_o      (spi_miso_o),
        .miso_oe_o   (spi_miso_oe_o),
        .req_valid_o (req_valid),
        .req_rw_o    (req_rw),
        .req_addr_o  (req_addr)
    );

    //////////////////////////////////////////////////////////////////////////
    // Crossing into the system clock. The request word only changes while
    // select is low, so it is quasi-static once the synced select is high.
    logic              cs_meta_reg;
    logic              cs_sync_reg;
    logic              cs_hold_reg;
    logic [8:0]        req_meta_reg;
    logic [8:0]        req_sync_reg;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cs_meta_reg  <= 1'b1;
            cs_sync_reg  <= 1'b1;
            cs_hold_reg  <= 1'b1;
            req_meta_reg <= 9'h000;
            req_sync_reg <= 9'h000;
        end else begin
            cs_meta_reg  <= spi_cs_n_i;
            cs_sync_reg  <= cs_meta_reg;
            cs_hold_reg  <= cs_sync_reg;
            req_meta_reg <= {req_valid, req_rw, req_addr};
            req_sync_reg <= req_meta_reg;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Sample timing
    logic [31:0]       smp_cnt_reg;
    logic [31:0]       smp_cnt_next;
    logic [7:0]        mag_cnt_reg;
    logic [7:0]        mag_cnt_next;
    logic              smp_tick;
    logic              mag_tick;

    assign smp_tick     = (smp_cnt_reg == (SAMPLE_CYCLES - 1));
    assign mag_tick     = smp_tick && (mag_cnt_reg == 8'(MAG_DIVIDE - 1));
    assign smp_cnt_next = smp_tick ? 32'h0000_0000 : smp_cnt_reg + 32'h0000_0001;
    assign mag_cnt_next = mag_tick ? 8'h00 :
                          (smp_tick ? mag_cnt_reg + 8'h01 : mag_cnt_reg);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            smp_cnt_reg <= 32'h0000_0000;
            mag_cnt_reg <= 8'h00;
        end else begin
            smp_cnt_reg <= smp_cnt_next;
            mag_cnt_reg <= mag_cnt_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Magnetometer low-bit masking: the lowest MAG_LOW_BITS minus decimation-count bits go dark
    logic [4:0]        dec_set;
    logic [4:0]        inactive_bits;
    logic [15:0]       mag_mask;

    assign dec_set       = sample_period_decimation_field_i[DEC_MSB:DEC_LSB];
    assign inactive_bits = (dec_set >= MAG_LOW_BITS) ? 5'h00 : MAG_LOW_BITS - dec_set;
    assign mag_mask      = 16'hFFFF << inactive_bits;

    //////////////////////////////////////////////////////////////////////////
    // Output data bank; only the sampler writes it, serial writes never reach it
    logic [15:0]       sample_w [NUM_REGS];
    logic [15:0]       bank_reg [NUM_REGS];

    assign sample_w[0]  = gyro_x_i;
    assign sample_w[1]  = gyro_y_i;
    assign sample_w[2]  = gyro_z_i;
    assign sample_w[3]  = accel_x_i;
    assign sample_w[4]  = accel_y_i;
    assign sample_w[5]  = accel_z_i;
    assign sample_w[6]  = mag_x_i & mag_mask;
    assign sample_w[7]  = mag_y_i & mag_mask;
    assign sample_w[8]  = mag_z_i & mag_mask;
    assign sample_w[9]  = pressure_i;
    assign sample_w[10] = {4'h0, temperature_i};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_REGS; gi++) begin : g_bank
            // Mag and pressure follow the slower magnetometer cadence
            localparam bit SLOW = (gi >= IDX_MAG_X) && (gi <= IDX_PRESSURE);
            wire load = SLOW ? mag_tick : smp_tick;
            always_ff @(posedge sys_clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    bank_reg[gi] <= DATA_RESET;
                end else if (load) begin
                    bank_reg[gi] <= sample_w[gi];
                end
            end
        end
    endgenerate

    //////////////////////////////////////////////////////////////////////////
    // Answer word. Frozen while the synced select is low so the link never sees a tear.
    logic [4:0]        hit;
    logic              answer_ok;
    logic [15:0]       read_word_next;

    assign hit            = reg_lookup(req_sync_reg[6:0]);
    // A write request leaves the next answer undefined; zero is sent
    assign answer_ok      = req_sync_reg[8] && !req_sync_reg[7] && hit[4];
    assign read_word_next = answer_ok ? bank_reg[hit[3:0]] : 16'h0000;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            read_word_reg <= 16'h0000;
        end else if (cs_sync_reg && cs_hold_reg) begin
            read_word_reg <= read_word_next;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Data-ready pulse after each sample cycle
    logic [15:0]       pulse_cnt_reg;
    logic [15:0]       pulse_cnt_next;

    assign pulse_cnt_next = smp_tick ? 16'(PULSE_CYCLES) :
                            ((pulse_cnt_reg != 16'h0000) ? pulse_cnt_reg - 16'h0001
                                                         : 16'h0000);

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pulse_cnt_reg           <= 16'h0000;
            first_digital_io_line_o <= 1'b0;
        end else begin
            pulse_cnt_reg           <= pulse_cnt_next;
            first_digital_io_line_o <= (pulse_cnt_next != 16'h0000);
        end
    end

endmodule // iodr_top
`default_nettype wire

// File: dv/iodr_top_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module iodr_top_assertions #(
    parameter int unsigned SAMPLE_CYCLES = 50,
    parameter int unsigned PULSE_CYCLES  = 5,
    parameter int unsigned MAG_DIVIDE    = 2
)(
    input  wire logic        sys_clk_i,
    input  wire logic        rstn_i,
    input  wire logic        spi_clk_i,
    input  wire logic        spi_cs_n_i,
    input  wire logic        spi_mosi_i,
    input  wire logic        spi_miso_o,
    input  wire logic        spi_miso_oe_o,
    input  wire logic [15:0] sample_period_decimation_field_i,
    input  wire logic        first_digital_io_line_o
);
    int unsigned hi_cnt, gap_cnt, up_cnt;
    logic        seen;
    logic        dio_q;
    logic [4:0]  nb;
    logic [15:0] rq_sh, rs_sh;
    logic [6:0]  last_addr;
    wire logic        dio    = first_digital_io_line_o;
    wire logic        dio_rise = dio && !dio_q;
    wire logic [15:0] rs_wd  = {rs_sh[14:0], spi_miso_o};
    wire logic [4:0]  dec    = sample_period_decimation_field_i[12:8];
    wire logic [15:0] lo_msk = (dec >= 5'h04) ? 16'h0000 : (16'h000F >> dec);
    wire logic        fr_end = (nb == 5'h0F);
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            hi_cnt <= 0;
            gap_cnt <= 0;
            up_cnt <= 0;
            seen <= 1'b0;
            dio_q <= 1'b0;
        end else begin
            hi_cnt <= dio ? hi_cnt + 1 : 0;
            gap_cnt <= dio_rise ? 1 : gap_cnt + 1;
            up_cnt <= (up_cnt < SAMPLE_CYCLES) ? up_cnt + 1 : up_cnt;
            seen <= seen | dio_rise;
            dio_q <= dio;
        end
    end
    // Bit count clears on deselect, so short frames cannot skew it
    always_ff @(posedge spi_clk_i or posedge spi_cs_n_i) begin
        if (spi_cs_n_i) nb <= 5'h00;
        else nb <= nb + 5'h01;
    end
    always_ff @(posedge spi_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rq_sh <= 16'h0000;
            rs_sh <= 16'h0000;
            last_addr <= 7'h00;
        end else begin
            rq_sh <= {rq_sh[14:0], spi_mosi_i};
            rs_sh <= {rs_sh[14:0], spi_miso_o};
            if (fr_end) last_addr <= rq_sh[13:7];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    AST_TEMP_TOP: assert property (@(posedge spi_clk_i) disable iff (!rstn_i)
        (fr_end && last_addr[6:1] == 6'h0C) |-> rs_wd[15:12] == 4'h0)
        else $error("temperature top bits not zero");
    AST_MAG_LOW: assert property (@(posedge spi_clk_i) disable iff (!rstn_i)
        (fr_end && last_addr[6:1] inside {6'h08, 6'h09, 6'h0A}) |-> (rs_wd & lo_msk) == 0)
        else $error("inactive magnetic bits set");
    AST_UNMAPPED: assert property (@(posedge spi_clk_i) disable iff (!rstn_i)
        (fr_end && (last_addr < 7'h04 || last_addr > 7'h19)) |-> rs_wd == 16'h0000)
        else $error("unmapped address answered nonzero");
    AST_OE_ON: assert property (@(posedge spi_clk_i) disable iff (!rstn_i)
        !spi_cs_n_i |-> spi_miso_oe_o)
        else $error("output not enabled in frame");
    AST_IDLE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        spi_cs_n_i |-> !spi_miso_oe_o && !spi_miso_o)
        else $error("output active while deselected");
    AST_MISO_EDGE: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (!spi_cs_n_i && !$stable(spi_miso_o)) |-> !spi_clk_i)
        else $error("output changed off the falling edge");
    AST_DIO_WIDTH: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        $fell(dio) |-> hi_cnt == PULSE_CYCLES)
        else $error("data-ready pulse width wrong");
    AST_DIO_PERIOD: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        ($rose(dio) && seen) |-> gap_cnt == SAMPLE_CYCLES)
        else $error("data-ready period wrong");
    AST_DIO_FIRST: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (up_cnt < SAMPLE_CYCLES) |-> !dio)
        else $error("data-ready before first sample");
    COV_DIO: cover property (@(posedge sys_clk_i) $rose(dio));
    COV_TEMP: cover property (@(posedge spi_clk_i) fr_end && last_addr == 7'h18);
    COV_MAG: cover property (@(posedge spi_clk_i) fr_end && last_addr == 7'h14);
endmodule // iodr_top_assertions

bind iodr_top iodr_top_assertions #(
    .SAMPLE_CYCLES(SAMPLE_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES),
    .MAG_DIVIDE(MAG_DIVIDE)
) u_iodr_top_assertions (.sys_clk_i, .rstn_i, .spi_clk_i, .spi_cs_n_i, .spi_mosi_i,
    .spi_miso_o, .spi_miso_oe_o, .sample_period_decimation_field_i,
    .first_digital_io_line_o);
`default_nettype wire

// File: dv/iodr_spi_host.sv
`timescale 1ns/10ps
`default_nettype none
module iodr_spi_host (
    output logic      sclk_o,
    output logic      cs_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    initial begin
        sclk_o = 1'b1;
        cs_n_o = 1'b1;
        mosi_o = 1'b0;
    end
    // Mode 3: drive on fall, sample on rise, clock parked high off-frame
    task automatic xfer(input logic [15:0] tx, input int nbit, output logic [15:0] rx);
        rx = 16'h0000;
        // Odd offset keeps link edges off the system clock edges
        #1.3;
        cs_n_o = 1'b0;
        #20;
        for (int i = 15; i > 15 - nbit; i--) begin
            sclk_o = 1'b0;
            mosi_o = tx[i];
            #7.5;
            sclk_o = 1'b1;
            rx = {rx[14:0], miso_i};
            #7.5;
        end
        cs_n_o = 1'b1;
        // Released line flips so a stale bit never reads as data
        mosi_o = ~mosi_o;
        #40;
    endtask
endmodule // iodr_spi_host
`default_nettype wire

// File: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam int unsigned SC = 50;
    localparam int unsigned PC = 5;
    localparam int unsigned MD = 2;
    logic        clk = 1'b0;
    logic        rstn = 1'b1;
    logic        sclk, cs_n, mosi, miso, oe, dio;
    logic [15:0] din [11];
    logic [15:0] dec = 16'h0000;
    logic [15:0] vals [11] = '{16'h61A8, 16'h9E58, 16'hFFFF, 16'h5460, 16'hABA0,
        16'h0001, 16'h33F4, 16'hCC0C, 16'hFFFF, 16'hEA60, 16'hFC3E};
    int          n_errors = 0;
    int          n_tests = 0;
    int          c;
    always #2.5 clk = ~clk;
    iodr_top #(.SAMPLE_CYCLES(SC), .PULSE_CYCLES(PC), .MAG_DIVIDE(MD)) u_iodr_top (
        .sys_clk_i(clk), .rstn_i(rstn), .spi_clk_i(sclk), .spi_cs_n_i(cs_n),
        .spi_mosi_i(mosi), .spi_miso_o(miso), .spi_miso_oe_o(oe),
        .gyro_x_i(din[0]), .gyro_y_i(din[1]), .gyro_z_i(din[2]), .accel_x_i(din[3]),
        .accel_y_i(din[4]), .accel_z_i(din[5]), .mag_x_i(din[6]), .mag_y_i(din[7]),
        .mag_z_i(din[8]), .pressure_i(din[9]), .temperature_i(din[10][11:0]),
        .sample_period_decimation_field_i(dec), .first_digital_io_line_o(dio));
    iodr_spi_host u_iodr_spi_host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
        .miso_i(miso));
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic wait_rise(output int cyc);
        cyc = 0;
        while (dio !== 1'b0 && cyc < 1000) begin
            @(posedge clk);
            cyc++;
        end
        while (dio !== 1'b1 && cyc < 1000) begin
            @(posedge clk);
            cyc++;
        end
        if (cyc >= 1000) begin
            n_errors++;
            $display("mismatch at %0t: no data-ready pulse", $time);
            tally_and_finish();
        end
    endtask
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        logic [15:0] r;
        u_iodr_spi_host.xfer({1'b0, a, 8'h00}, 16, r);
        u_iodr_spi_host.xfer(16'h0000, 16, r);
        check(r, exp);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_dio();
        int w;
        wait_rise(w);
        wait_rise(w);
        check(16'(w), 16'(SC));
        w = 0;
        while (dio === 1'b1 && w < 1000) begin
            @(posedge clk);
            w++;
        end
        check(16'(w), 16'(PC));
        $display("test dio done");
    endtask
    task automatic t_values();
        logic [15:0] e;
        @(posedge clk);
        foreach (din[i]) din[i] <= vals[i];
        repeat (2 * MD) wait_rise(c);
        for (int i = 0; i < 11; i++) begin
            e = (i >= 6 && i <= 8) ? (vals[i] & 16'hFFF0) : vals[i];
            if (i == 10) e = {4'h0, vals[i][11:0]};
            rd(7'(4 + 2 * i), e);
            rd(7'(5 + 2 * i), e);
        end
        $display("test values done");
    endtask
    task automatic t_decim();
        logic [4:0] ds [4] = '{5'h01, 5'h02, 5'h04, 5'h08};
        foreach (ds[k]) begin
            @(posedge clk);
            dec <= {3'h0, ds[k], 8'h00};
            repeat (2 * MD) wait_rise(c);
            rd(7'h14, ~((ds[k] >= 5'h04) ? 16'h0000 : (16'h000F >> ds[k])));
        end
        $display("test decimation done");
    endtask
    task automatic t_link();
        logic [15:0] r;
        u_iodr_spi_host.xfer(16'h84AA, 16, r);
        u_iodr_spi_host.xfer(16'h0400, 16, r);
        check(r, 16'h0000);
        u_iodr_spi_host.xfer(16'h0600, 16, r);
        check(r, vals[0]);
        u_iodr_spi_host.xfer(16'h0000, 8, r);
        u_iodr_spi_host.xfer(16'h0000, 16, r);
        check(r, vals[1]);
        rd(7'h1A, 16'h0000);
        rd(7'h02, 16'h0000);
        $display("test link done");
    endtask
    task automatic t_reset();
        logic [15:0] r;
        // A pending request must not survive reset
        u_iodr_spi_host.xfer(16'h0400, 16, r);
        @(posedge clk);
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        check(16'(dio), 16'h0000);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        u_iodr_spi_host.xfer(16'h0000, 16, r);
        check(r, 16'h0000);
        check(16'(oe), 16'h0000);
        $display("test reset done");
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        foreach (din[i]) din[i] = 16'h0000;
        // A real falling edge, so link-side flops see the reset too
        rstn <= 1'b0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (4) @(posedge clk);
        t_dio();
        t_values();
        t_decim();
        t_link();
        t_reset();
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
